// ---- board_model.sv ----
// Board-side model: pull-ups on released pads and a power-button switch
`timescale 1ns/1ps
`default_nettype none
module board_model
  import dsw_pad_pkg::*;
(
  input  wire logic                  clk,
  input  wire dsw_pad_pkg::pad_ctl_t pad_ctl,
  input  wire logic                  button_n,
  input  wire logic                  wake_n,
  output logic [NUM_PADS-1:0]        pad_in
);
  import dsw_pad_pkg::*;
  logic [NUM_PADS-1:0] lvl;
  always_comb
  begin
    lvl = pad_ctl.out | pad_ctl.oe_n;
    lvl[PAD_POWER_BUTTON_N] = button_n & lvl[PAD_POWER_BUTTON_N];
    lvl[0]          = wake_n & lvl[0];
  end
  // Registered on the rising edge like a pad input stage, so bench changes
  // made at the falling edge never race the update
  always_ff @(posedge clk) pad_in <= lvl;
endmodule
`default_nettype wire

// ---- deep_sleep_pad_control.sv ----
// Deep-sleep-well pad control: sleep outputs, reserved strap, debounce, pulls
`timescale 1ns/1ps
`default_nettype none
// Contract
// - S3, S4, S5 and aux sleep pads are native outputs when their strap is 0, else inputs; native drives low in reset and the sequencer level after.
// - Wireless sleep and LAN PHY power pads follow the same strap choice, drive low in reset and the sequencer level after.
// - The reserved strap is sampled at the rise of deep-sleep power good, must read high, and then becomes an output driven low.
// - Second deglitch class pads stay high impedance with pull-down during their power sequencing.
// - The power-button pad has a debouncer of 8 to 32768 RTC periods chosen by a config field.
// - All pad pulls are off after reset and each is enabled separately by firmware.
// - Strap pads have their pull enabled during reset; the code pulls up only the power-button pad, not the reserved strap.
module deep_sleep_pad_control
  import dsw_pad_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      ce,
  input  wire dsw_pad_pkg::sleep_set_t   soft_strap,
  input  wire dsw_pad_pkg::sleep_set_t   native_level,
  input  wire logic                      suspend_clock_src,
  input  wire logic                      power_seq_active,
  input  wire logic                      deep_sleep_power_good,
  input  wire logic                      rtc_clk,
  input  wire logic [3:0]                debounce_sel,
  input  wire logic [NUM_PADS-1:0]       cfg_pull_up,
  input  wire logic [NUM_PADS-1:0]       cfg_pull_down,
  input  wire logic [NUM_PADS-1:0]       pad_in,
  output dsw_pad_pkg::pad_ctl_t          pad_ctl,
  output logic [NUM_PADS-1:0]            gpi_level,
  output logic                           power_button_n,
  output logic                           strap_sampled,
  output logic                           strap_value
);
  import dsw_pad_pkg::*;

  pad_ctl_t               pad_q;
  pad_ctl_t               pad_d;
  logic [NUM_PADS-1:0]    base_out;
  logic [NUM_PADS-1:0]    base_oe_n;
  logic [NUM_PADS-1:0]    gpi_q;
  logic                   rtc_prev_q;
  logic                   rtc_tick;
  logic                   pg_prev_q;
  strap_state_t           strap_q;
  strap_state_t           strap_d;
  logic                   strap_val_q;
  logic                   strap_val_d;
  logic [NUM_PADS-1:0]    native_sel;
  logic [NUM_PADS-1:0]    native_val;
  logic [NUM_PADS-1:0]    gpi_d;
  logic                   rtc_prev_d;
  logic                   pg_prev_d;

  // Per-pad native choice and native level; unused positions stay inputs
  always_comb
  begin
    native_sel             = '0;
    native_val             = '0;
    native_sel[PAD_S3]     = (soft_strap.s3 == NATIVE_SEL);
    native_sel[PAD_S4]     = (soft_strap.s4 == NATIVE_SEL);
    native_sel[PAD_S5]     = (soft_strap.s5 == NATIVE_SEL);
    native_sel[PAD_AUX]    = (soft_strap.aux == NATIVE_SEL);
    native_sel[PAD_WLAN]   = (soft_strap.wlan == NATIVE_SEL);
    native_sel[PAD_LANPHY] = (soft_strap.lanphy == NATIVE_SEL);
    // Suspend clock pad has no strap choice and is always native
    native_sel[PAD_SUSPEND_CLOCK_OUT] = 1'b1;
    native_val[PAD_S3]     = native_level.s3;
    native_val[PAD_S4]     = native_level.s4;
    native_val[PAD_S5]     = native_level.s5;
    native_val[PAD_AUX]    = native_level.aux;
    native_val[PAD_WLAN]   = native_level.wlan;
    native_val[PAD_LANPHY] = native_level.lanphy;
    native_val[PAD_SUSPEND_CLOCK_OUT] = suspend_clock_src;
  end

  // Functional drive before sequencing and pull overrides
  always_comb
  begin
    base_out  = native_val;
    base_oe_n = ~native_sel;
    // Strap pad floats until sampled so the board pull-up sets the level
    base_out[PAD_RSV]  = 1'b0;
    // Driven low once taken, so the strap net does not float while power good stays high
    base_oe_n[PAD_RSV] = (strap_q != ST_SAMPLED);
  end

  // Parking during sequencing overrides strap choice and firmware pulls
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PADS; gi++)
    begin : g_pad
      always_comb
      begin
        if (DEG2_MASK[gi] && power_seq_active)
        begin
          pad_d.out[gi]       = 1'b0;
          pad_d.oe_n[gi]      = 1'b1;
          pad_d.pull_up[gi]   = 1'b0;
          pad_d.pull_down[gi] = 1'b1;
        end
        else
        begin
          pad_d.out[gi]       = base_out[gi];
          pad_d.oe_n[gi]      = base_oe_n[gi];
          pad_d.pull_up[gi]   = cfg_pull_up[gi];
          pad_d.pull_down[gi] = cfg_pull_down[gi];
        end
      end
    end
  endgenerate

  // Strap capture; losing power good re-arms it
  always_comb
  begin
    strap_d     = strap_q;
    strap_val_d = strap_val_q;
    pg_prev_d   = deep_sleep_power_good;
    case (strap_q)
      ST_WAIT_PG:
      begin
        if (deep_sleep_power_good && !pg_prev_q)
        begin
          strap_val_d = pad_in[PAD_RSV];
          strap_d     = ST_SAMPLED;
        end
      end
      ST_SAMPLED:
      begin
        if (!deep_sleep_power_good)
        begin
          strap_d = ST_WAIT_PG;
        end
      end
      default:
      begin
        strap_d = ST_WAIT_PG;
      end
    endcase
  end

  // Plain input stage; pads are taken as synchronous to clk
  always_comb
  begin
    gpi_d      = pad_in;
    rtc_prev_d = rtc_clk;
  end

  // RTC clock treated as a slow sampled level, not a second clock domain
  // Limitation: an RTC level already high at reset release counts as a tick
  assign rtc_tick = rtc_clk && !rtc_prev_q;

  // Only the power-button pad keeps its pull-up in reset, not the strap pad; firmware pulls take over after
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pad_q.out       <= RST_OUT;
      pad_q.oe_n      <= RST_OE_N;
      pad_q.pull_up   <= STRAP_PU_MASK;
      pad_q.pull_down <= STRAP_PD_MASK;
    end
    else if (ce)
    begin
      pad_q <= pad_d;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gpi_q      <= '0;
      rtc_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      gpi_q      <= gpi_d;
      rtc_prev_q <= rtc_prev_d;
    end
  end

  // Power good already high at release counts as a rise, so the strap is taken
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pg_prev_q   <= 1'b0;
      strap_q     <= ST_WAIT_PG;
      strap_val_q <= 1'b0;
    end
    else if (ce)
    begin
      pg_prev_q   <= pg_prev_d;
      strap_q     <= strap_d;
      strap_val_q <= strap_val_d;
    end
  end

  // Filter sits on the raw pad; gpi_level keeps the unfiltered copy
  power_button_n_debounce u_debounce (
    .clk        (clk),
    .resetn     (resetn),
    .ce         (ce),
    .rtc_tick   (rtc_tick),
    .period_sel (debounce_sel),
    .raw_n      (pad_in[PAD_POWER_BUTTON_N]),
    .level_n    (power_button_n)
  );

  // Registered outputs; strap_sampled decodes the state register
  assign pad_ctl       = pad_q;
  assign gpi_level     = gpi_q;
  assign strap_sampled = (strap_q == ST_SAMPLED);
  assign strap_value   = strap_val_q;

endmodule
`default_nettype wire

// ---- deep_sleep_pad_control_test.sv ----
// Self-checking bench for the deep-sleep-well pad control
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_pad_control_test;
  import dsw_pad_pkg::*;
  // Reset is asserted on the first falling edge so the registers see an edge
  logic                clk = 1'b1;
  logic                resetn = 1'b1;
  logic                seq = 1'b0;
  logic                pg = 1'b0;
  logic                button_n = 1'b1;
  logic                wake_n = 1'b1;
  logic [2:0]          div = 3'h0;
  logic [3:0]          dsel = 4'h0;
  sleep_set_t          strap = 6'h00;
  sleep_set_t          nat = 6'h00;
  logic [NUM_PADS-1:0] cpu = 12'h000;
  logic [NUM_PADS-1:0] cpd = 12'h000;
  logic [NUM_PADS-1:0] pad_in;
  pad_ctl_t            pad_ctl;
  logic [NUM_PADS-1:0] gpi_level;
  logic                power_button_n;
  logic                strap_sampled;
  logic                strap_value;
  int                  mismatches = 0;
  int                  samples_checked = 0;
  always #2 clk = ~clk;
  // RTC period is eight clk cycles
  always @(negedge clk) div <= div + 3'h1;
  deep_sleep_pad_control deep_sleep_pad_control_i (.clk, .resetn, .ce(1'b1), .soft_strap(strap),
    .native_level(nat), .suspend_clock_src(1'b0), .power_seq_active(seq),
    .deep_sleep_power_good(pg), .rtc_clk(div[2]), .debounce_sel(dsel), .cfg_pull_up(cpu),
    .cfg_pull_down(cpd), .pad_in, .pad_ctl, .gpi_level, .power_button_n, .strap_sampled,
    .strap_value);
  board_model board_model_i (.clk, .pad_ctl, .button_n, .wake_n, .pad_in);
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [NUM_PADS-1:0] got, input logic [NUM_PADS-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic t_reset();
    chk(pad_ctl.oe_n, 12'h08f);
    chk(pad_ctl.out | pad_ctl.pull_down, 12'h000);
    chk(pad_ctl.pull_up, 12'h008);
    resetn = 1'b1;
    cyc(2);
    chk(pad_ctl.pull_up | pad_ctl.pull_down, 12'h000);
    chk((pad_ctl.oe_n | pad_ctl.out) & 12'he70, 12'h000);
  endtask
  task automatic t_native();
    nat = 6'h3f;
    cyc(2);
    chk(pad_ctl.out & 12'he70, 12'he70);
    strap = 6'h3f;
    cyc(2);
    chk(pad_ctl.oe_n & 12'he70, 12'he70);
    strap = 6'h00;
  endtask
  task automatic t_pulls_seq();
    cpu = 12'ha5a;
    cpd = 12'h5a5;
    cyc(2);
    chk(pad_ctl.pull_up, 12'ha5a);
    chk(pad_ctl.pull_down, 12'h5a5);
    seq = 1'b1;
    cyc(2);
    chk(pad_ctl.oe_n & 12'hf70, 12'hf70);
    chk(pad_ctl.pull_down, 12'hff5);
    chk(pad_ctl.pull_up, 12'h00a);
    seq = 1'b0;
  endtask
  task automatic t_strap();
    pg = 1'b1;
    cyc(3);
    chk({8'h00, strap_sampled, strap_value, pad_ctl.oe_n[PAD_RSV], pad_ctl.out[PAD_RSV]}, 12'h00c);
    pg = 1'b0;
    cyc(3);
    chk({10'h000, strap_sampled, pad_ctl.oe_n[PAD_RSV]}, 12'h001);
  endtask
  // Pulse on an input-only pad held 1000 cycles, 4 us at this clock
  task automatic t_gpi();
    wake_n = 1'b0;
    cyc(1000);
    chk({9'h000, gpi_level[2:0]}, 12'h006);
    wake_n = 1'b1;
    cyc(2);
    chk({9'h000, gpi_level[2:0]}, 12'h007);
  endtask
  // Short excursion first, then a held change; timing counted in clk cycles
  task automatic t_button(input logic lvl, input logic [3:0] sel, input int lo, input int hi);
    int n;
    dsel = sel;
    button_n = lvl;
    cyc(40);
    button_n = ~lvl;
    cyc(80);
    chk({11'h000, power_button_n}, {11'h000, ~lvl});
    button_n = lvl;
    n = 0;
    while (power_button_n !== lvl && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk({11'h000, n >= lo && n <= hi}, 12'h001);
    if (n >= 400)
      wrap_up();
  endtask
  initial
  begin
    @(negedge clk);
    resetn = 1'b0;
    cyc(3);
    t_reset();
    t_native();
    t_pulls_seq();
    t_strap();
    t_button(1'b0, 4'h0, 56, 72);
    t_button(1'b1, 4'h1, 120, 136);
    t_gpi();
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- dsw_pad_pkg.sv ----
// Shared constants and carrier types for the deep-sleep-well pad control
package dsw_pad_pkg;

  localparam int unsigned NUM_PADS = 12;

  // Pad positions within the deep-sleep-well group
  localparam int unsigned PAD_POWER_BUTTON_N = 3;
  localparam int unsigned PAD_S3     = 4;
  localparam int unsigned PAD_S4     = 5;
  localparam int unsigned PAD_AUX    = 6;
  localparam int unsigned PAD_RSV    = 7;
  localparam int unsigned PAD_SUSPEND_CLOCK_OUT = 8;
  localparam int unsigned PAD_WLAN   = 9;
  localparam int unsigned PAD_S5     = 10;
  localparam int unsigned PAD_LANPHY = 11;

  // Pads of the second output deglitch class
  localparam logic [NUM_PADS-1:0] DEG2_MASK     = 12'hf70;
  // Pads whose pulls are on while in reset: only the power-button pad pull-up, not the strap pad
  localparam logic [NUM_PADS-1:0] STRAP_PU_MASK = 12'h008;
  localparam logic [NUM_PADS-1:0] STRAP_PD_MASK = 12'h000;
  // Output enable (active low) held in reset: sleep pads drive low
  localparam logic [NUM_PADS-1:0] RST_OE_N      = 12'h08f;
  localparam logic [NUM_PADS-1:0] RST_OUT       = 12'h000;

  localparam logic NATIVE_SEL = 1'b0;
  localparam logic BTN_IDLE   = 1'b1;

  // Debounce period is 8 << sel RTC periods, sel 0..12 gives 8..32768
  localparam int unsigned DBNC_CNT_W    = 16;
  localparam logic [3:0]  DBNC_SEL_MAX  = 4'hc;
  localparam logic [DBNC_CNT_W-1:0] DBNC_BASE = 16'h0008;

  typedef struct packed {
    logic s3;
    logic s4;
    logic s5;
    logic aux;
    logic wlan;
    logic lanphy;
  } sleep_set_t;

  typedef struct packed {
    logic [NUM_PADS-1:0] out;
    logic [NUM_PADS-1:0] oe_n;
    logic [NUM_PADS-1:0] pull_up;
    logic [NUM_PADS-1:0] pull_down;
  } pad_ctl_t;

  typedef enum logic [1:0] {
    ST_WAIT_PG = 2'b00,
    ST_SAMPLED = 2'b01
  } strap_state_t;

endpackage

// ---- dsw_pad_sva.sv ----
// Assertion checker for the deep-sleep-well pad control
`timescale 1ns/1ps
`default_nettype none
module dsw_pad_sva
  import dsw_pad_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    ce,
  input wire dsw_pad_pkg::sleep_set_t soft_strap,
  input wire dsw_pad_pkg::sleep_set_t native_level,
  input wire logic                    power_seq_active,
  input wire logic                    deep_sleep_power_good,
  input wire logic [NUM_PADS-1:0]     cfg_pull_up,
  input wire logic [NUM_PADS-1:0]     pad_in,
  input wire dsw_pad_pkg::pad_ctl_t   pad_ctl,
  input wire logic                    power_button_n,
  input wire logic                    strap_sampled,
  input wire logic                    strap_value
);
  import dsw_pad_pkg::*;
  logic [7:0] stab_q;
  logic [7:0] stab_d;
  logic       btn_q;
  // Cycles the button input has held; saturates so long holds stay legal
  always_comb stab_d = (pad_in[PAD_POWER_BUTTON_N] != btn_q) ? 8'h00 : stab_q + {7'h00, stab_q != 8'hff};
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) {stab_q, btn_q} <= 9'h001;
    else {stab_q, btn_q} <= {stab_d, pad_in[PAD_POWER_BUTTON_N]};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_sleep_native: assert property (ce && !power_seq_active && !soft_strap.s3
    |=> !pad_ctl.oe_n[PAD_S3] && pad_ctl.out[PAD_S3] == $past(native_level.s3)) else $error("s3 pad");
  a_sleep_gpi: assert property (ce && !power_seq_active && soft_strap.s4
    |=> pad_ctl.oe_n[PAD_S4]) else $error("s4 pad not released");
  a_wlan_native: assert property (ce && !power_seq_active && !soft_strap.wlan
    |=> !pad_ctl.oe_n[PAD_WLAN] && pad_ctl.out[PAD_WLAN] == $past(native_level.wlan))
    else $error("wlan pad");
  a_seq_hiz: assert property (ce && power_seq_active |=> (pad_ctl.oe_n & DEG2_MASK) == DEG2_MASK
    && (pad_ctl.pull_down & DEG2_MASK) == DEG2_MASK && (pad_ctl.pull_up & DEG2_MASK) == 12'h000)
    else $error("sequencing pads not parked");
  a_strap_sample: assert property (ce && deep_sleep_power_good && !$past(deep_sleep_power_good)
    && !strap_sampled |=> strap_sampled && strap_value == $past(pad_in[PAD_RSV]))
    else $error("strap not sampled");
  a_strap_drive: assert property (ce && strap_sampled && deep_sleep_power_good
    |=> !pad_ctl.oe_n[PAD_RSV] && !pad_ctl.out[PAD_RSV]) else $error("strap pad not low");
  a_pull_cfg: assert property (ce && !power_seq_active
    |=> pad_ctl.pull_up == $past(cfg_pull_up)) else $error("pull-up not per config");
  a_reset_state: assert property (disable iff (1'b0) !resetn |-> pad_ctl.out == RST_OUT
    && pad_ctl.oe_n == RST_OE_N && pad_ctl.pull_up == STRAP_PU_MASK) else $error("reset pad state");
  a_debounce_hold: assert property ($changed(power_button_n) |-> $past(stab_q) >= 8'd14
    && power_button_n == $past(pad_in[PAD_POWER_BUTTON_N])) else $error("button passed too early");
  c_strap: cover property (strap_sampled && strap_value);
  c_press: cover property ($fell(power_button_n));
  c_seq: cover property (power_seq_active);
endmodule
bind deep_sleep_pad_control dsw_pad_sva dsw_pad_sva_i (.clk, .resetn, .ce, .soft_strap,
  .native_level, .power_seq_active, .deep_sleep_power_good, .cfg_pull_up, .pad_in, .pad_ctl,
  .power_button_n, .strap_sampled, .strap_value);
`default_nettype wire

// ---- power_button_n_debounce.sv ----
// Power-button debouncer counting RTC clock periods
`timescale 1ns/1ps
`default_nettype none
module power_button_n_debounce
  import dsw_pad_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       rtc_tick,
  input  wire logic [3:0] period_sel,
  input  wire logic       raw_n,
  output logic            level_n
);

  logic [DBNC_CNT_W-1:0] cnt_q;
  logic [DBNC_CNT_W-1:0] cnt_d;
  logic                  level_q;
  logic                  level_d;
  logic [3:0]            sel_c;
  logic [DBNC_CNT_W-1:0] limit;

  always_comb
  begin
    sel_c = (period_sel > DBNC_SEL_MAX) ? DBNC_SEL_MAX : period_sel;
    limit = DBNC_CNT_W'(DBNC_BASE << sel_c) - DBNC_CNT_W'(1);
    cnt_d   = cnt_q;
    level_d = level_q;
    // Any return to the held level discards the excursion
    if (raw_n == level_q)
    begin
      cnt_d = '0;
    end
    else if (rtc_tick)
    begin
      if (cnt_q == limit)
      begin
        level_d = raw_n;
        cnt_d   = '0;
      end
      else
      begin
        cnt_d = cnt_q + DBNC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q   <= '0;
      level_q <= BTN_IDLE;
    end
    else if (ce)
    begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  assign level_n = level_q;

endmodule
`default_nettype wire
